// ==== abort_cause.sv ====
// Function
// - Slave transmitter bus loss sets bit 14.
// - Bus loss also sets bit 12 together.
// - Compare sampled SDA with driven bit.
// - Read request with TX data sets 13.
// - Master arbitration loss sets bit 12.
// - Master start while disabled sets 11.
// - No restart, 10-bit read sets 10.
// - No restart, START byte sets 9.
// - Bit 9 reasserts one cycle after clear.
// - No restart, high-speed transfer sets 8.
// - Acknowledged START byte sets bit 7.
// - Acknowledged high-speed master code sets 6.
// - Unacknowledged general call sets 4.
// - Master data not acknowledged sets 3.
// - Cause word read-only, resets to zero.
module abort_cause (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Controller events, same clock
   input wire logic slave_tx_active,
   input wire logic slave_tx_bit,
   input wire logic slave_read_request,
   input wire logic tx_fifo_not_empty,
   input wire logic master_arbitration_lost,
   input wire logic master_start_request,
   input wire logic master_read_cmd,
   input wire logic start_byte_request,
   input wire logic highspeed_request,
   input wire logic start_byte_ack,
   input wire logic highspeed_code_ack,
   input wire logic gencall_sent,
   input wire logic next_cmd_read,
   input wire logic gencall_nack,
   input wire logic addr_acked,
   input wire logic data_nack,
   // Outputs
   output logic transfer_abort,
   output logic tx_fifo_flush,
   output logic irq
);

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_prev;
      logic [15:0] cause;
      logic [15:0] config_word;
      logic [0:0] irq_status;
      logic [0:0] irq_mask;
      logic [15:0] rdata;
      logic abort;
      logic flush;
      logic irq;
   } state_t;

   state_t cur;
   state_t nxt;

   logic [15:0] set_vec;
   logic scl_rise;
   logic bus_mismatch;
   logic no_repeat;
   logic start_byte_cause;
   logic clear_write;

   ////////////////////////////////////////////////////////////////////////////
   // Cause detection.

   always_comb begin
      scl_rise = cur.scl_sync[1] & ~cur.scl_prev;
      clear_write = reg_write && (reg_addr == abort_cause_pkg::ADDR_CLEAR);
      bus_mismatch = slave_tx_active & scl_rise & (cur.sda_sync[1] != slave_tx_bit);
      no_repeat = ~cur.config_word[abort_cause_pkg::CFG_REPEAT_START_ENABLE];
      // The START-byte cause is a level: it stays while the request is held and the config allows it.
      start_byte_cause = no_repeat & start_byte_request
         & cur.config_word[abort_cause_pkg::CFG_SPECIAL]
         & cur.config_word[abort_cause_pkg::CFG_GENCALL_OR_STARTBYTE_SELECT];
      set_vec = '0;
      set_vec[abort_cause_pkg::BIT_SLAVE_TX_BUS_LOST] = bus_mismatch;
      set_vec[abort_cause_pkg::BIT_SLAVE_STALE_FLUSH] =
         slave_read_request & tx_fifo_not_empty;
      set_vec[abort_cause_pkg::BIT_ARBITRATION_LOST] = master_arbitration_lost | bus_mismatch;
      set_vec[abort_cause_pkg::BIT_MASTER_DISABLED_ATTEMPT] = master_start_request
         & ~cur.config_word[abort_cause_pkg::CFG_MASTER_ENABLE];
      set_vec[abort_cause_pkg::BIT_TENBIT_READ_NO_REPEAT] = no_repeat & master_read_cmd
         & cur.config_word[abort_cause_pkg::CFG_TENBIT_ADDR];
      set_vec[abort_cause_pkg::BIT_START_BYTE_NO_REPEAT] = start_byte_cause;
      set_vec[abort_cause_pkg::BIT_HIGHSPEED_NO_REPEAT] = no_repeat & highspeed_request;
      set_vec[abort_cause_pkg::BIT_START_BYTE_ACKED] = start_byte_ack;
      set_vec[abort_cause_pkg::BIT_HIGHSPEED_CODE_ACKED] = highspeed_code_ack;
      set_vec[abort_cause_pkg::BIT_GENCALL_THEN_READ] = gencall_sent & next_cmd_read;
      set_vec[abort_cause_pkg::BIT_GENCALL_UNACKED] = gencall_sent & gencall_nack;
      set_vec[abort_cause_pkg::BIT_DATA_UNACKED] = addr_acked & data_nack;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      nxt = cur;
      nxt.scl_sync = {cur.scl_sync[0], scl_in};
      nxt.sda_sync = {cur.sda_sync[0], sda_in};
      nxt.scl_prev = cur.scl_sync[1];
      // A write to the clear register drops all causes; new events win over it.
      // The START-byte flag is the one exception: a clear drops it for one cycle even
      // while its cause persists, so software can see that the clear was premature.
      if (clear_write) begin
         nxt.cause = abort_cause_pkg::CAUSE_RESET | set_vec;
         nxt.cause[abort_cause_pkg::BIT_START_BYTE_NO_REPEAT] = 1'b0;
      end else begin
         nxt.cause = cur.cause | set_vec;
      end
      if (reg_write && reg_addr == abort_cause_pkg::ADDR_CONFIG) begin
         nxt.config_word = reg_wdata;
      end
      if (reg_write && reg_addr == abort_cause_pkg::ADDR_IRQ_MASK) begin
         nxt.irq_mask = reg_wdata[0:0];
      end
      if (reg_write && reg_addr == abort_cause_pkg::ADDR_IRQ_STATUS) begin
         nxt.irq_status = cur.irq_status & ~reg_wdata[0:0];
      end
      nxt.abort = |set_vec;
      nxt.flush = |set_vec;
      if (|set_vec) begin
         nxt.irq_status[abort_cause_pkg::IRQ_TX_ABORT] = 1'b1;
      end
      nxt.irq = |(nxt.irq_status & nxt.irq_mask);
      nxt.rdata = '0;
      if (reg_read) begin
         case (reg_addr)
            abort_cause_pkg::ADDR_CAUSE: begin
               nxt.rdata = cur.cause;
            end
            abort_cause_pkg::ADDR_IRQ_STATUS: begin
               nxt.rdata = {15'h0000, cur.irq_status};
            end
            abort_cause_pkg::ADDR_IRQ_MASK: begin
               nxt.rdata = {15'h0000, cur.irq_mask};
            end
            abort_cause_pkg::ADDR_CONFIG: begin
               nxt.rdata = cur.config_word;
            end
            default: begin
               nxt.rdata = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cur <= '0;
         cur.cause <= abort_cause_pkg::CAUSE_RESET;
         cur.config_word <= abort_cause_pkg::CONFIG_RESET;
      end else if (clk_en) begin
         cur <= nxt;
      end
   end

   assign reg_rdata = cur.rdata;
   assign transfer_abort = cur.abort;
   assign tx_fifo_flush = cur.flush;
   assign irq = cur.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_SLAVE_LOST: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && bus_mismatch) |=> cur.cause[abort_cause_pkg::BIT_SLAVE_TX_BUS_LOST])
      else $error("slave bus loss not latched");

   AST_ARB_WITH_SLAVE: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(cur.cause[abort_cause_pkg::BIT_SLAVE_TX_BUS_LOST])
      |-> cur.cause[abort_cause_pkg::BIT_ARBITRATION_LOST])
      else $error("bit 12 missing with bit 14");

   // Judged from the synchronised pin history, not from the internal edge detector.
   AST_MISMATCH: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && slave_tx_active && $rose(cur.scl_sync[1])
       && (cur.sda_sync[1] != slave_tx_bit))
      |=> cur.cause[abort_cause_pkg::BIT_SLAVE_TX_BUS_LOST])
      else $error("sampled data mismatch not treated as bus loss");

   AST_FLUSH: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && slave_read_request && tx_fifo_not_empty)
      |=> (cur.cause[abort_cause_pkg::BIT_SLAVE_STALE_FLUSH] && tx_fifo_flush))
      else $error("stale flush not raised");

   AST_MASTER_ARB: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && master_arbitration_lost) |=> cur.cause[abort_cause_pkg::BIT_ARBITRATION_LOST])
      else $error("arbitration loss not latched");

   AST_MASTER_DIS: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && master_start_request
       && !cur.config_word[abort_cause_pkg::CFG_MASTER_ENABLE])
      |=> cur.cause[abort_cause_pkg::BIT_MASTER_DISABLED_ATTEMPT])
      else $error("master disabled attempt not latched");

   AST_REASSERT: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && start_byte_cause && !clear_write)
      |=> cur.cause[abort_cause_pkg::BIT_START_BYTE_NO_REPEAT])
      else $error("start byte cause not reasserted");

   AST_BIT9_DROP: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && clear_write && start_byte_cause)
      |=> !cur.cause[abort_cause_pkg::BIT_START_BYTE_NO_REPEAT])
      else $error("start byte flag did not drop on clear");

   AST_DATA_NACK: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && addr_acked && data_nack) |=> cur.cause[abort_cause_pkg::BIT_DATA_UNACKED])
      else $error("data nack not latched");

   AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && |set_vec) |=> (transfer_abort && cur.irq_status[0]) ##1 (irq == cur.irq_mask[0]))
      else $error("abort or interrupt missing");

   AST_TENBIT: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && master_read_cmd && no_repeat
       && cur.config_word[abort_cause_pkg::CFG_TENBIT_ADDR])
      |=> cur.cause[abort_cause_pkg::BIT_TENBIT_READ_NO_REPEAT])
      else $error("ten-bit read without restart not latched");

   AST_SBYTE: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && start_byte_request && no_repeat && !clear_write
       && cur.config_word[abort_cause_pkg::CFG_SPECIAL]
       && cur.config_word[abort_cause_pkg::CFG_GENCALL_OR_STARTBYTE_SELECT])
      |=> cur.cause[abort_cause_pkg::BIT_START_BYTE_NO_REPEAT])
      else $error("start byte without restart not latched");

   AST_HS_NORESTART: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && highspeed_request && no_repeat)
      |=> cur.cause[abort_cause_pkg::BIT_HIGHSPEED_NO_REPEAT])
      else $error("high-speed without restart not latched");

   AST_SBYTE_ACK: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && start_byte_ack) |=> cur.cause[abort_cause_pkg::BIT_START_BYTE_ACKED])
      else $error("acknowledged start byte not latched");

   AST_HS_ACK: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && highspeed_code_ack) |=> cur.cause[abort_cause_pkg::BIT_HIGHSPEED_CODE_ACKED])
      else $error("acknowledged master code not latched");

   AST_GC_READ: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && gencall_sent && next_cmd_read)
      |=> cur.cause[abort_cause_pkg::BIT_GENCALL_THEN_READ])
      else $error("general call then read not latched");

   AST_GC_NACK: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && gencall_sent && gencall_nack)
      |=> cur.cause[abort_cause_pkg::BIT_GENCALL_UNACKED])
      else $error("unacknowledged general call not latched");

   // Software writes to the cause word must never change it.
   AST_CAUSE_RO: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_write && (reg_addr == abort_cause_pkg::ADDR_CAUSE) && (set_vec == '0))
      |=> (cur.cause == $past(cur.cause)))
      else $error("cause word changed by a write");

endmodule // abort_cause

// ==== abort_cause_pkg.sv ====
package abort_cause_pkg;

   // Register map of this block (word offsets, byte address = offset).
   localparam logic [7:0] ADDR_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0C;
   localparam logic [7:0] ADDR_CLEAR = 8'h10;

   localparam int CAUSE_W = 16;
   localparam logic [15:0] CAUSE_RESET = 16'h0000;

   // Field positions inside the abort-cause word.
   localparam int BIT_SLAVE_TX_BUS_LOST = 14;
   localparam int BIT_SLAVE_STALE_FLUSH = 13;
   localparam int BIT_ARBITRATION_LOST = 12;
   localparam int BIT_MASTER_DISABLED_ATTEMPT = 11;
   localparam int BIT_TENBIT_READ_NO_REPEAT = 10;
   localparam int BIT_START_BYTE_NO_REPEAT = 9;
   localparam int BIT_HIGHSPEED_NO_REPEAT = 8;
   localparam int BIT_START_BYTE_ACKED = 7;
   localparam int BIT_HIGHSPEED_CODE_ACKED = 6;
   localparam int BIT_GENCALL_THEN_READ = 5;
   localparam int BIT_GENCALL_UNACKED = 4;
   localparam int BIT_DATA_UNACKED = 3;

   // Config register fields.
   localparam int CFG_MASTER_ENABLE = 0;
   localparam int CFG_REPEAT_START_ENABLE = 5;
   localparam int CFG_TENBIT_ADDR = 6;
   localparam int CFG_SPECIAL = 11;
   localparam int CFG_GENCALL_OR_STARTBYTE_SELECT = 10;
   localparam logic [15:0] CONFIG_RESET = 16'h0021;

   // Interrupt status bits.
   localparam int IRQ_TX_ABORT = 0;
   localparam int IRQ_W = 1;
   localparam logic [15:0] CLEAR_ALL = 16'hFFFF;

endpackage

// ==== abort_cause_tb.sv ====
module abort_cause_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CAUSE = abort_cause_pkg::ADDR_CAUSE;
   localparam logic [7:0] STAT = abort_cause_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] MASK = abort_cause_pkg::ADDR_IRQ_MASK;
   localparam logic [7:0] CFG = abort_cause_pkg::ADDR_CONFIG;
   localparam logic [7:0] CLR = abort_cause_pkg::ADDR_CLEAR;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [13:0] ev = 14'h0000;
   logic run = 1'b0;
   logic corrupt = 1'b0;
   logic tx_act = 1'b0;
   logic [15:0] reg_rdata;
   logic [15:0] d;
   logic scl_in, sda_in, transfer_abort, tx_fifo_flush, irq;
   int err_count = 0;
   int num_checks = 0;
   always #2 ref_clk = ~ref_clk;
   bus_peer peer (.ref_clk(ref_clk), .run(run), .corrupt(corrupt), .tx_bit(1'b1),
      .scl_in(scl_in), .sda_in(sda_in));
   abort_cause dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .scl_in(scl_in), .sda_in(sda_in), .slave_tx_active(tx_act), .slave_tx_bit(1'b1),
      .data_nack(ev[0]), .addr_acked(ev[1]), .gencall_nack(ev[2]), .gencall_sent(ev[3]),
      .next_cmd_read(ev[4]), .highspeed_code_ack(ev[5]), .start_byte_ack(ev[6]),
      .highspeed_request(ev[7]), .start_byte_request(ev[8]), .master_read_cmd(ev[9]),
      .master_start_request(ev[10]), .master_arbitration_lost(ev[11]), .slave_read_request(ev[12]),
      .tx_fifo_not_empty(ev[13]), .transfer_abort(transfer_abort),
      .tx_fifo_flush(tx_fifo_flush), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(CAUSE, d);
      chk("cause after reset", d, 16'h0000);
      wr(CAUSE, 16'hFFFF);
      rd(CAUSE, d);
      chk("cause after write", d, 16'h0000);
      rd(8'h20, d);
      chk("unmapped read", d, 16'h0000);
      clk_en <= 1'b0;
      ev <= 14'h0003;
      @(posedge ref_clk);
      ev <= 14'h0000;
      clk_en <= 1'b1;
      rd(CAUSE, d);
      chk("cause frozen", d, 16'h0000);
   endtask
   task automatic t_causes();
      logic [15:0] cfg [11] = '{16'h0021, 16'h0021, 16'h0021, 16'h0021, 16'h0021, 16'h0001,
         16'h0C01, 16'h0041, 16'h0020, 16'h0021, 16'h0021};
      logic [13:0] evs [11] = '{14'h0003, 14'h000C, 14'h0018, 14'h0020, 14'h0040, 14'h0080,
         14'h0100, 14'h0200, 14'h0400, 14'h0800, 14'h3000};
      for (int i = 0; i < 11; i++) begin
         wr(CFG, cfg[i]);
         @(posedge ref_clk);
         ev <= evs[i];
         @(posedge ref_clk);
         ev <= 14'h0000;
         #1 chk("abort and flush", {transfer_abort, tx_fifo_flush}, 16'h0003);
         rd(CAUSE, d);
         chk("cause bit", d, 16'h0008 << i);
         wr(CLR, 16'hFFFF);
      end
      wr(CFG, 16'h0021);
   endtask
   task automatic t_bus_loss();
      tx_act <= 1'b1;
      run <= 1'b1;
      corrupt <= 1'b1;
      repeat (8) @(posedge ref_clk);
      run <= 1'b0;
      tx_act <= 1'b0;
      corrupt <= 1'b0;
      rd(CAUSE, d);
      chk("slave bus loss", d, 16'h5000);
      wr(CLR, 16'hFFFF);
   endtask
   // A lingering start-byte cause must reassert bit 9 after the clear.
   task automatic t_restart_hold();
      wr(CFG, 16'h0C01);
      ev <= 14'h0100;
      wr(CLR, 16'hFFFF);
      rd(CAUSE, d);
      chk("bit 9 reasserted", d, 16'h0200);
      ev <= 14'h0000;
      wr(CLR, 16'hFFFF);
      rd(CAUSE, d);
      chk("bit 9 cleared", d, 16'h0000);
      wr(CFG, 16'h0021);
   endtask
   task automatic t_irq();
      wr(MASK, 16'h0001);
      ev <= 14'h0003;
      @(posedge ref_clk);
      ev <= 14'h0000;
      repeat (2) @(posedge ref_clk);
      #1 chk("irq raised", {15'h0000, irq}, 16'h0001);
      rd(STAT, d);
      chk("irq status", d, 16'h0001);
      wr(MASK, 16'h0000);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq masked", {15'h0000, irq}, 16'h0000);
      wr(MASK, 16'h0001);
      wr(CLR, 16'hFFFF);
      wr(STAT, 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_causes();
      t_bus_loss();
      t_restart_hold();
      t_irq();
      end_of_test();
   end
   // The whole run needs about 160 cycles; this leaves a wide margin.
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
endmodule // abort_cause_tb

// ==== bus_peer.sv ====
module bus_peer (
   // Clock and controls
   input wire logic ref_clk,
   input wire logic run,
   input wire logic corrupt,
   input wire logic tx_bit,
   // Bus lines
   output logic scl_in,
   output logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_in = 1'b1;
   end
   // The clock line rests at its pull-up level outside a frame.
   always @(posedge ref_clk) begin
      scl_in <= run ? ~scl_in : 1'b1;
   end
   // An overdriving peer forces the opposite level, which the slave must notice.
   assign sda_in = !run ? 1'b1 : (corrupt ? ~tx_bit : tx_bit);
endmodule // bus_peer
